//--- design/pulse_and_analog_threshold_trigger.sv
// Pulse and analog threshold trigger with an AXI4-Lite register slave.
// Assumes pulse_in, analog_sample and ref_values are synchronous to aclk.
`timescale 1ns/1ns
module pulse_and_analog_threshold_trigger
	import trig_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = GATE_TICK_CYCLES
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic pulse_in,
	input wire logic signed [15:0] analog_sample,
	input wire logic [REF_N*32-1:0] ref_values,
	output logic [31:0] measured_frequency,
	output logic signed [31:0] analog_value,
	output logic freq_switch,
	output logic analog_switch
);

	typedef struct packed {
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] f_on;
		logic [15:0] f_off;
		logic [15:0] gate;
		logic signed [15:0] gain;
		logic signed [15:0] offset;
		logic signed [15:0] an_on;
		logic signed [15:0] an_off;
		logic [11:0] ref_sel;
		logic pulse_prev;
		logic [TICK_W-1:0] tick_cnt;
		logic [15:0] gate_cnt;
		logic [31:0] pulse_count;
		logic [31:0] measured;
		logic freq_sw;
		logic signed [31:0] an_value;
		logic an_sw;
	} state_t;

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	state_t q;
	state_t d;
	logic rise;
	logic tick;
	logic gate_end;
	logic signed [31:0] gate_len;
	logic signed [31:0] an_on_eff;
	logic signed [31:0] an_off_eff;

	// Saturate a value into a documented range
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input logic signed [31:0] lo,
		input logic signed [31:0] hi);
		if (v < lo)
		begin
			return lo;
		end
		if (v > hi)
		begin
			return hi;
		end
		return v;
	endfunction

	// Threshold decision shared by both front ends
	function automatic logic thresh_eval(input logic signed [31:0] v, input logic signed [31:0] on_lvl,
		input logic signed [31:0] off_lvl, input logic prev);
		if (on_lvl >= off_lvl)
		begin
			if (v > on_lvl)
			begin
				return 1'b1;
			end
			if (v <= off_lvl)
			begin
				return 1'b0;
			end
			return prev;
		end
		return (v >= on_lvl) && (v < off_lvl);
	endfunction

	// Byte-lane merge of a write into the current contents
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				m[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// Current value of a referenced function block
	function automatic logic signed [31:0] ref_pick(input logic [REF_N*32-1:0] refs, input logic [3:0] sel);
		return $signed(refs[sel[REF_SEL_W-1:0]*32 +: 32]);
	endfunction

	// Register words are sign- or zero-extended for read-back
	function automatic logic signed [31:0] sx(input logic [15:0] v);
		return $signed({{16{v[15]}}, v});
	endfunction

	// AXI handshakes: one write and one read in flight, back-pressure while an answer is pending
	assign awready = !q.aw_held && !q.bvalid;
	assign wready = !q.w_held && !q.bvalid;
	assign arready = !q.rvalid;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign measured_frequency = q.measured;
	assign analog_value = q.an_value;
	assign freq_switch = q.freq_sw;
	assign analog_switch = q.an_sw;

	// Gate timebase is a fixed 10 ms tick; no selector exists for it
	assign tick = (q.tick_cnt == TICK_LAST);
	assign rise = pulse_in && !q.pulse_prev;
	// Gate length from the register or a referenced block, clamped to 0..99.99 s
	assign gate_len = q.ctrl[CTRL_GATE_REF] ?
		clamp(ref_pick(ref_values, q.ref_sel[REF_GATE_LSB +: 4]), FREQ_MIN, GATE_MAX) :
		$signed({16'h0, q.gate});
	assign gate_end = tick && (gate_len != 32'sh0) && ($signed({16'h0, q.gate_cnt}) >= gate_len - 32'sd1);
	// Analog levels from the registers or from referenced blocks
	assign an_on_eff = q.ctrl[CTRL_ON_REF] ?
		clamp(ref_pick(ref_values, q.ref_sel[REF_ON_LSB +: 4]), -AN_LIM, AN_LIM) : sx(q.an_on);
	assign an_off_eff = q.ctrl[CTRL_OFF_REF] ?
		clamp(ref_pick(ref_values, q.ref_sel[REF_OFF_LSB +: 4]), -AN_LIM, AN_LIM) : sx(q.an_off);

	// Next-state logic for bus, counters and switches
	always_comb
	begin
		logic [31:0] merged;
		logic [31:0] new_meas;
		merged = RESET_WORD;
		new_meas = q.pulse_count + {31'h0, rise};
		d = q;

		// Write address and data may arrive in either order
		if (awvalid && awready)
		begin
			d.aw_held = 1'b1;
			d.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			d.w_held = 1'b1;
			d.w_data = wdata;
			d.w_strb = wstrb;
		end
		if (q.bvalid && bready)
		begin
			d.bvalid = 1'b0;
		end
		if (q.aw_held && q.w_held)
		begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			// Values are clamped on entry so the compare never sees an illegal level
			case (q.aw_addr)
				OFS_CTRL:
				begin
					merged = lane_merge({26'h0, q.ctrl}, q.w_data, q.w_strb);
					d.ctrl = merged[CTRL_W-1:0];  // Decimal field kept for display only
				end
				OFS_FREQ_ON:
				begin
					merged = lane_merge({16'h0, q.f_on}, q.w_data, q.w_strb);
					d.f_on = 16'(clamp($signed(merged), FREQ_MIN, FREQ_MAX));
				end
				OFS_FREQ_OFF:
				begin
					merged = lane_merge({16'h0, q.f_off}, q.w_data, q.w_strb);
					d.f_off = 16'(clamp($signed(merged), FREQ_MIN, FREQ_MAX));
				end
				OFS_GATE:
				begin
					merged = lane_merge({16'h0, q.gate}, q.w_data, q.w_strb);
					d.gate = 16'(clamp($signed(merged), FREQ_MIN, GATE_MAX));
				end
				OFS_GAIN:
				begin
					merged = lane_merge(sx(q.gain), q.w_data, q.w_strb);
					d.gain = 16'(clamp($signed(merged), -GAIN_LIM, GAIN_LIM));
				end
				OFS_OFFSET:
				begin
					merged = lane_merge(sx(q.offset), q.w_data, q.w_strb);
					d.offset = 16'(clamp($signed(merged), -OFFSET_LIM, OFFSET_LIM));
				end
				OFS_AN_ON:
				begin
					merged = lane_merge(sx(q.an_on), q.w_data, q.w_strb);
					d.an_on = 16'(clamp($signed(merged), -AN_LIM, AN_LIM));
				end
				OFS_AN_OFF:
				begin
					merged = lane_merge(sx(q.an_off), q.w_data, q.w_strb);
					d.an_off = 16'(clamp($signed(merged), -AN_LIM, AN_LIM));
				end
				OFS_REF_SEL:
				begin
					merged = lane_merge({20'h0, q.ref_sel}, q.w_data, q.w_strb);
					d.ref_sel = merged[11:0];
				end
				OFS_STATUS, OFS_MEAS, OFS_AN_VALUE, OFS_PULSE_CNT:
				begin
					d.bresp = RESP_OKAY;  // Read-only words ignore writes
				end
				default:
				begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read path: data captured at the address handshake
		if (q.rvalid && rready)
		begin
			d.rvalid = 1'b0;
		end
		if (arvalid && arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			case (araddr)
				OFS_CTRL: d.rdata = {26'h0, q.ctrl};
				OFS_FREQ_ON: d.rdata = {16'h0, q.f_on};
				OFS_FREQ_OFF: d.rdata = {16'h0, q.f_off};
				OFS_GATE: d.rdata = {16'h0, q.gate};
				OFS_GAIN: d.rdata = sx(q.gain);
				OFS_OFFSET: d.rdata = sx(q.offset);
				OFS_AN_ON: d.rdata = sx(q.an_on);
				OFS_AN_OFF: d.rdata = sx(q.an_off);
				OFS_REF_SEL: d.rdata = {20'h0, q.ref_sel};
				OFS_STATUS: d.rdata = {30'h0, q.an_sw, q.freq_sw};
				OFS_MEAS: d.rdata = q.measured;
				OFS_AN_VALUE: d.rdata = q.an_value;
				OFS_PULSE_CNT: d.rdata = q.pulse_count;
				default:
				begin
					d.rdata = RESET_WORD;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Free-running 10 ms tick
		d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
		d.pulse_prev = pulse_in;

		// Gate counting; a zero gate parks the measurement and keeps the last result
		if (gate_len == 32'sh0)
		begin
			d.gate_cnt = '0;
			d.pulse_count = '0;
		end
		else if (gate_end)
		begin
			d.measured = new_meas;
			d.pulse_count = '0;
			d.gate_cnt = '0;
			d.freq_sw = thresh_eval($signed(new_meas), sx(q.f_on), sx(q.f_off), q.freq_sw);
		end
		else
		begin
			if (tick)
			begin
				d.gate_cnt = q.gate_cnt + 16'h1;
			end
			if (rise)
			begin
				d.pulse_count = q.pulse_count + 32'h1;
			end
		end

		// Analog path is pipelined: value one clock, decision the next
		d.an_value = (sx(analog_sample) * sx(q.gain)) / GAIN_SCALE + sx(q.offset);
		d.an_sw = thresh_eval(q.an_value, an_on_eff, an_off_eff, q.an_sw);
	end

	// State register with synchronous reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Counting takes rising edges only
	property p_rise_count;
		(rise && !gate_end && gate_len != 32'sh0) |=> (q.pulse_count == $past(q.pulse_count) + 32'h1);
	endproperty
	a_rise_count: assert property (p_rise_count) else $error("rising edge not counted");

	property p_no_count;
		(!rise && !gate_end && gate_len != 32'sh0) |=> $stable(q.pulse_count);
	endproperty
	a_no_count: assert property (p_no_count) else $error("count moved without rising edge");

	property p_latch;
		gate_end |=> (q.measured == $past(q.pulse_count) + {31'h0, $past(rise)}) && (q.pulse_count == 32'h0);
	endproperty
	a_latch: assert property (p_latch) else $error("gate total not latched or count not cleared");

	property p_once_per_gate;
		!gate_end |=> $stable(q.freq_sw) && $stable(q.measured);
	endproperty
	a_once_per_gate: assert property (p_once_per_gate) else $error("frequency output moved mid gate");

	property p_freq_hyst;
		(q.f_on >= q.f_off) ##1 (gate_end && $stable(q.f_on) && $stable(q.f_off)) |=>
			(q.measured > q.f_on) ? q.freq_sw : ((q.measured <= q.f_off) ? !q.freq_sw : $stable(q.freq_sw));
	endproperty
	a_freq_hyst: assert property (p_freq_hyst) else $error("hysteresis decision wrong");

	property p_freq_window;
		(gate_end && q.f_on < q.f_off) |=>
			(q.freq_sw == ((q.measured >= $past(q.f_on)) && (q.measured < $past(q.f_off))));
	endproperty
	a_freq_window: assert property (p_freq_window) else $error("window decision wrong");

	property p_analog_calc;
		1'b1 |=> q.an_value == (sx($past(analog_sample)) * sx($past(q.gain))) / GAIN_SCALE + sx($past(q.offset));
	endproperty
	a_analog_calc: assert property (p_analog_calc) else $error("analog value not gain times sample plus offset");

	property p_analog_window;
		(an_on_eff < an_off_eff) |=> (q.an_sw == (($past(q.an_value) >= $past(an_on_eff)) &&
			($past(q.an_value) < $past(an_off_eff))));
	endproperty
	a_analog_window: assert property (p_analog_window) else $error("analog window decision wrong");

	property p_gain_range;
		(sx(q.gain) >= -GAIN_LIM) && (sx(q.gain) <= GAIN_LIM) && (sx(q.offset) >= -OFFSET_LIM) &&
			(sx(q.offset) <= OFFSET_LIM);
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("gain or offset out of range");

	property p_level_range;
		(sx(q.an_on) >= -AN_LIM) && (sx(q.an_on) <= AN_LIM) && (sx(q.an_off) >= -AN_LIM) &&
			(sx(q.an_off) <= AN_LIM) && (gate_len <= GATE_MAX);
	endproperty
	a_level_range: assert property (p_level_range) else $error("level or gate out of range");

endmodule

//--- design/trig_pkg.sv
// Package for the pulse and analog threshold trigger: register map, limits, reset values and timing.
// Assumes a 10 MHz register clock; all thresholds and values are raw integers.
package trig_pkg;

	// Clock and gate timebase
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned GATE_TICK_NS = 10_000_000;  // Gate counts in hundredths of a second
	localparam int unsigned GATE_TICK_CYCLES = GATE_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W = 17;
	localparam int unsigned PULSE_MAX_HZ = 5000;  // Edge detector needs only one clock per level

	// Referenced function blocks
	localparam int unsigned REF_N = 8;
	localparam int unsigned REF_SEL_W = 3;

	// AXI4-Lite
	localparam int unsigned ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FREQ_ON = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FREQ_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GATE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_OFFSET = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_AN_ON = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_AN_OFF = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_REF_SEL = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_MEAS = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_AN_VALUE = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_PULSE_CNT = 8'h30;

	// Control fields
	localparam int unsigned CTRL_W = 6;
	localparam int unsigned CTRL_GATE_REF = 0;
	localparam int unsigned CTRL_ON_REF = 1;
	localparam int unsigned CTRL_OFF_REF = 2;
	localparam int unsigned CTRL_DEC_LSB = 4;
	localparam int unsigned REF_GATE_LSB = 0;
	localparam int unsigned REF_ON_LSB = 4;
	localparam int unsigned REF_OFF_LSB = 8;
	localparam int unsigned STAT_FREQ_SW = 0;
	localparam int unsigned STAT_AN_SW = 1;

	// Value limits
	localparam logic signed [31:0] FREQ_MIN = 32'sh0;
	localparam logic signed [31:0] FREQ_MAX = 32'sd9999;
	localparam logic signed [31:0] GATE_MAX = 32'sd9999;
	localparam logic signed [31:0] GAIN_LIM = 32'sd1000;
	localparam logic signed [31:0] GAIN_SCALE = 32'sd100;
	localparam logic signed [31:0] OFFSET_LIM = 32'sd10000;
	localparam logic signed [31:0] AN_LIM = 32'sd20000;

	// Every register and counter resets to zero
	localparam logic [31:0] RESET_WORD = 32'h0;

endpackage

//--- test/pulse_and_analog_source.sv
// Model of the pulse line and analog channel that feed the trigger.
// Assumes one clock shared with the trigger; its outputs change after rising edges.
`timescale 1ns/1ns
module pulse_and_analog_source
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] half,
	input wire logic signed [15:0] level,
	output logic pulse_in,
	output logic signed [15:0] analog_sample
);
	logic [7:0] cnt_q;
	// Square wave of 2*half clocks, idle low when half is zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn || half == 8'h0)
		begin
			cnt_q <= 8'h0;
			pulse_in <= 1'b0;
		end
		else if (cnt_q >= half - 8'h1)
		begin
			cnt_q <= 8'h0;
			pulse_in <= !pulse_in; // Fast line wired straight in
		end
		else
			cnt_q <= cnt_q + 8'h1;
	end
	// Channel value held one clock, as a converter would present it
	always_ff @(posedge aclk)
		analog_sample <= level;
endmodule

//--- test/tb_pulse_and_analog_threshold_trigger.sv
// Self-checking bench for the threshold trigger: register table, analog and pulse paths.
// Assumes a 10 MHz clock and a gate tick shortened to 10 clocks.
`timescale 1ns/1ns
module tb_pulse_and_analog_threshold_trigger;
	import trig_pkg::*;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [1:0] rs;} row_t;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pulse_in, freq_switch, analog_switch;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, half;
	logic [31:0] wdata, rdata, measured_frequency, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic signed [15:0] level, analog_sample;
	logic signed [31:0] analog_value;
	logic [REF_N*32-1:0] ref_values;
	row_t rows [8];
	int fails, checked, cycles, i;
	pulse_and_analog_threshold_trigger #(.TICK_CYCLES(10)) u_pulse_and_analog_threshold_trigger (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pulse_in(pulse_in), .analog_sample(analog_sample), .ref_values(ref_values),
		.measured_frequency(measured_frequency), .analog_value(analog_value),
		.freq_switch(freq_switch), .analog_switch(analog_switch));
	pulse_and_analog_source u_pulse_and_analog_source (.aclk(aclk), .aresetn(aresetn), .half(half),
		.level(level), .pulse_in(pulse_in), .analog_sample(analog_sample));
	// Free-running clock, 100 ns period
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard; the longest gate test needs about 2100 clocks
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	// Ready is sampled at the falling edge, which holds the value the next rising edge sees
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_t = 1'b0;
		// No cycle limit of its own: the hang guard ends a stuck transfer
		while (!b_t)
		begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
		end
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_t = 1'b0;
		while (!r_t)
		begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
		end
	endtask
	// Analog value lands two clocks after the channel, the switch one clock later
	task automatic an_step(input logic signed [15:0] s, input logic signed [31:0] ev, input logic esw);
		@(posedge aclk);
		level <= s;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		check(analog_value, ev);
		check({31'h0, analog_switch}, {31'h0, esw});
	endtask
	// Steady pulse rate: any whole gate sees the same number of rising edges
	task automatic fr_step(input logic [7:0] h, input int w, input logic [31:0] em, input logic esw);
		@(posedge aclk);
		half <= h;
		repeat (w) @(posedge aclk);
		@(negedge aclk);
		check(measured_frequency, em);
		check({31'h0, freq_switch}, {31'h0, esw});
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, half, level} = '0;
		wstrb = 4'hf;
		ref_values = '0;
		rows[0] = '{OFS_GATE, 32'd12000, 32'd9999, RESP_OKAY};
		rows[1] = '{OFS_GAIN, 32'hfffff830, 32'hfffffc18, RESP_OKAY};
		rows[2] = '{OFS_OFFSET, 32'h00004e20, 32'h00002710, RESP_OKAY};
		rows[3] = '{OFS_AN_ON, 32'hffff8ad0, 32'hffffb1e0, RESP_OKAY};
		rows[4] = '{OFS_CTRL, 32'h00000030, 32'h00000030, RESP_OKAY};
		rows[5] = '{OFS_STATUS, 32'h00000003, 32'h00000000, RESP_OKAY};
		rows[6] = '{8'h40, 32'h00000005, 32'h00000000, RESP_SLVERR};
		rows[7] = '{OFS_FREQ_ON, 32'd10000, 32'd9999, RESP_OKAY};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check(measured_frequency, RESET_WORD);
		check({30'h0, freq_switch, analog_switch}, RESET_WORD);
		axi_read(OFS_AN_OFF, rd, rs);
		check(rd, RESET_WORD);
		// Register table: clamping, read-only, unmapped
		for (i = 0; i < 8; i++)
		begin
			axi_write(rows[i].a, rows[i].d, rs);
			check({30'h0, rs}, {30'h0, rows[i].rs});
			axi_read(rows[i].a, rd, rs);
			check(rd, rows[i].rd);
			check({30'h0, rs}, {30'h0, rows[i].rs});
		end
		// Gate and on level from other blocks, three decimals set
		ref_values[63:32] <= 32'd2000;
		ref_values[95:64] <= 32'd2;
		axi_write(OFS_REF_SEL, 32'h00000012, rs);
		axi_write(OFS_CTRL, 32'h00000033, rs);
		axi_write(OFS_GAIN, 32'd250, rs);
		axi_write(OFS_OFFSET, 32'hffffff9c, rs);
		axi_write(OFS_AN_OFF, 32'd1000, rs);
		an_step(16'sd1000, 32'sd2400, 1'b1);
		an_step(16'sd500, 32'sd1150, 1'b1);
		an_step(16'sd400, 32'sd900, 1'b0);
		an_step(-16'sd3, -32'sd107, 1'b0);
		ref_values[63:32] <= 32'd1000;
		axi_write(OFS_AN_OFF, 32'd2000, rs);
		an_step(16'sd440, 32'sd1000, 1'b1);
		an_step(16'sd840, 32'sd2000, 1'b0);
		an_step(16'sd500, 32'sd1150, 1'b1);
		// Pulse path, gate of 2 ticks from block 2
		axi_write(OFS_FREQ_ON, 32'd5, rs);
		axi_write(OFS_FREQ_OFF, 32'd3, rs);
		fr_step(8'd1, 45, 32'd10, 1'b1);
		fr_step(8'd2, 45, 32'd5, 1'b1);
		fr_step(8'd5, 45, 32'd2, 1'b0);
		axi_write(OFS_FREQ_ON, 32'd4, rs);
		axi_write(OFS_FREQ_OFF, 32'd10, rs);
		fr_step(8'd2, 45, 32'd5, 1'b1);
		fr_step(8'd1, 45, 32'd10, 1'b0);
		axi_read(OFS_MEAS, rd, rs);
		check(rd, 32'd10);
		// Gate of 100 hundredths, one scaled second, from the register
		axi_write(OFS_CTRL, 32'h00000000, rs);
		axi_write(OFS_GATE, 32'd100, rs);
		fr_step(8'd5, 2100, 32'd100, 1'b0);
		// Reset in mid-run clears the result, both switches and the registers
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check(measured_frequency, RESET_WORD);
		check({30'h0, freq_switch, analog_switch}, RESET_WORD);
		axi_read(OFS_GATE, rd, rs);
		check(rd, RESET_WORD);
		tally_and_finish();
	end
endmodule
